// *** include/txc_defs.svh ***
`ifndef TXC_DEFS_SVH
`define TXC_DEFS_SVH

// Register port widths
`define TXC_ADDR_W 6
`define TXC_DATA_W 8
`define TXC_NUM_REGS 6

// Register indices on the management port
`define TXC_IDX_GAIN 6'h0B
`define TXC_IDX_MOD 6'h0C
`define TXC_IDX_OUTM 6'h0D
`define TXC_IDX_XPT 6'h0E
`define TXC_IDX_BIASH 6'h0F
`define TXC_IDX_BIASL 6'h10

// Reset value and write masks
`define TXC_RESET_VAL 8'h00
`define TXC_FULL_MASK 8'hFF
`define TXC_BIASL_MASK 8'h03
`define TXC_READ_NONE 8'h00

// Gain-shaping register fields
`define TXC_AMP_RNG_BIT 7
`define TXC_PK_BIT 6
`define TXC_TC_HI_BIT 5
`define TXC_TC_LO_BIT 4
`define TXC_EQ_MSB 3
`define TXC_EQ_LSB 0

// Output-mode register fields
`define TXC_LEG_BIT 7
`define TXC_SE_BIT 6
`define TXC_DLY_BIT 5
`define TXC_SLOW_BIT 4
`define TXC_DE_MSB 3
`define TXC_DE_LSB 0

// Cross-point register fields
`define TXC_XDIR_BIT 7
`define TXC_XMAG_MSB 6
`define TXC_XMAG_LSB 0

// Bias code layout
`define TXC_BIAS_W 10
`define TXC_BIASL_MSB 1
`define TXC_BIASL_LSB 0

// Photodiode range codes
`define TXC_PD_RNG_FINE 2'h0
`define TXC_PD_RNG_MID 2'h1

// Bias current per code in nA: 750, 1500, 3000, open loop 156000
`define TXC_LSB_NA_W 18
`define TXC_PD_LSB_NA_FINE 18'h002EE
`define TXC_PD_LSB_NA_MID 18'h005DC
`define TXC_PD_LSB_NA_COARSE 18'h00BB8
`define TXC_OL_LSB_NA 18'h26160

// Modulation swing per code in uVpp: 9500
`define TXC_SWING_W 22
`define TXC_MOD_STEP_UVPP 22'h00251C

`endif

// *** include/txc_pkg.sv ***
`include "txc_defs.svh"

package txc_pkg;

    typedef logic [`TXC_DATA_W-1:0] txc_byte_t;

    typedef logic [`TXC_ADDR_W-1:0] txc_addr_t;

    typedef enum logic [`TXC_ADDR_W-1:0] {
        txc_reg_gain = `TXC_IDX_GAIN,
        txc_reg_mod = `TXC_IDX_MOD,
        txc_reg_outm = `TXC_IDX_OUTM,
        txc_reg_xpt = `TXC_IDX_XPT,
        txc_reg_biash = `TXC_IDX_BIASH,
        txc_reg_biasl = `TXC_IDX_BIASL
    } txc_reg_t;

endpackage : txc_pkg

// *** testbench/txc_tx_config_tb.sv ***
`timescale 1ns/1ps
`include "txc_defs.svh"

module txc_tx_config_tb;
    logic clk;
    logic reset;
    logic reg_wr_en;
    logic reg_rd_en;
    logic closed_loop_en;
    logic [1:0] photodiode_range_sel;
    txc_pkg::txc_addr_t reg_addr;
    txc_pkg::txc_byte_t reg_wdata;
    txc_pkg::txc_byte_t reg_rdata;
    logic reg_rd_valid;
    logic amp_half_range_sel, peaking_width_sel;
    logic temp_comp_sel_hi, temp_comp_sel_lo;
    logic [3:0] input_eq_strength;
    logic [7:0] modulation_level_code;
    logic single_leg_select, single_ended_sel;
    logic delayed_deemph_sel, slow_edge_sel;
    logic [3:0] deemph_strength;
    logic crosspoint_direction;
    logic [6:0] crosspoint_magnitude;
    logic [`TXC_BIAS_W-1:0] bias_code;
    logic positive_output_leg, negative_output_leg;
    logic [`TXC_SWING_W-1:0] mod_swing_uvpp;
    logic [`TXC_LSB_NA_W-1:0] bias_lsb_na;
    // Shadow of what every register should hold, index 0 is gain
    txc_pkg::txc_byte_t mir [6];
    txc_pkg::txc_byte_t pats [4] = '{8'hA5, 8'h5A, 8'h00, 8'hFF};
    int n_fail;
    int tests_run;

    txc_tx_config u_dut (
        .clk(clk), .reset(reset), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .closed_loop_en(closed_loop_en),
        .photodiode_range_sel(photodiode_range_sel),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .amp_half_range_sel(amp_half_range_sel),
        .peaking_width_sel(peaking_width_sel),
        .temp_comp_sel_hi(temp_comp_sel_hi),
        .temp_comp_sel_lo(temp_comp_sel_lo),
        .input_eq_strength(input_eq_strength),
        .modulation_level_code(modulation_level_code),
        .single_leg_select(single_leg_select),
        .single_ended_sel(single_ended_sel),
        .delayed_deemph_sel(delayed_deemph_sel),
        .slow_edge_sel(slow_edge_sel), .deemph_strength(deemph_strength),
        .crosspoint_direction(crosspoint_direction),
        .crosspoint_magnitude(crosspoint_magnitude), .bias_code(bias_code),
        .positive_output_leg(positive_output_leg),
        .negative_output_leg(negative_output_leg),
        .mod_swing_uvpp(mod_swing_uvpp), .bias_lsb_na(bias_lsb_na)
    );

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk

    // Writes to unmapped indices must leave the shadow alone
    task wr(input txc_pkg::txc_addr_t a, input txc_pkg::txc_byte_t d);
        @(posedge clk);
        reg_wr_en <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'h0;
        if (a >= `TXC_IDX_GAIN && a <= `TXC_IDX_BIASL) begin
            mir[a - `TXC_IDX_GAIN] = (a == `TXC_IDX_BIASL) ?
                (d & `TXC_BIASL_MASK) : d;
        end
    endtask : wr

    task rd(input txc_pkg::txc_addr_t a, input txc_pkg::txc_byte_t e);
        @(posedge clk);
        reg_rd_en <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'h0;
        @(negedge clk);
        chk(reg_rd_valid, 1'h1);
        chk(reg_rdata, e);
        @(negedge clk);
        chk(reg_rd_valid, 1'h0);
    endtask : rd

    task chk_scale;
        @(negedge clk);
        if (!closed_loop_en) begin
            chk(bias_lsb_na, `TXC_OL_LSB_NA);
        end else if (photodiode_range_sel[1]) begin
            chk(bias_lsb_na, `TXC_PD_LSB_NA_COARSE);
        end else if (photodiode_range_sel[0]) begin
            chk(bias_lsb_na, `TXC_PD_LSB_NA_MID);
        end else begin
            chk(bias_lsb_na, `TXC_PD_LSB_NA_FINE);
        end
    endtask : chk_scale

    // Reads back every register, then checks every field output
    task chk_all;
        for (int i = 0; i < 6; i++) begin
            rd(`TXC_IDX_GAIN + 6'(i), mir[i]);
        end
        chk(amp_half_range_sel, mir[0][7]);
        chk(peaking_width_sel, mir[0][6]);
        chk(temp_comp_sel_hi, mir[0][5]);
        chk(temp_comp_sel_lo, mir[0][4]);
        chk(input_eq_strength, mir[0][3:0]);
        chk(modulation_level_code, mir[1]);
        chk(mod_swing_uvpp, 32'(mir[1]) * `TXC_MOD_STEP_UVPP);
        chk(single_leg_select, mir[2][7]);
        chk(single_ended_sel, mir[2][6]);
        chk(delayed_deemph_sel, mir[2][5]);
        chk(slow_edge_sel, mir[2][4]);
        chk(deemph_strength, mir[2][3:0]);
        chk(positive_output_leg, !mir[2][6] || !mir[2][7]);
        chk(negative_output_leg, !mir[2][6] || mir[2][7]);
        chk(crosspoint_direction, mir[3][7]);
        chk(crosspoint_magnitude, mir[3][6:0]);
        chk(bias_code, {mir[4], mir[5][1:0]});
    endtask : chk_all

    initial begin
        repeat (20000) @(posedge clk);
        $display("timeout while waiting on the design");
        n_fail++;
        end_sim;
    end

    initial begin
        n_fail = 0;
        tests_run = 0;
        reset = 1'h1;
        reg_wr_en = 1'h0;
        reg_rd_en = 1'h0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        closed_loop_en = 1'h0;
        photodiode_range_sel = 2'h0;
        foreach (mir[i]) mir[i] = 8'h00;
        repeat (20) @(posedge clk);
        reset <= 1'h0;
        chk_all;
        chk_scale;
        // Patterns give differential, single positive and single negative
        foreach (pats[p]) begin
            for (int i = 0; i < 6; i++) begin
                wr(`TXC_IDX_GAIN + 6'(i), pats[p] ^ 8'(i));
            end
            chk_all;
        end
        // Unmapped indices neither store nor read back
        wr(6'h0A, 8'hFF);
        wr(6'h11, 8'hFF);
        rd(6'h0A, 8'h00);
        rd(6'h11, 8'h00);
        chk_all;
        // Read and write on one edge: the read sees the older value
        @(posedge clk);
        reg_wr_en <= 1'h1;
        reg_rd_en <= 1'h1;
        reg_addr <= `TXC_IDX_BIASH;
        reg_wdata <= 8'h3C;
        @(posedge clk);
        reg_wr_en <= 1'h0;
        reg_rd_en <= 1'h0;
        @(negedge clk);
        chk(reg_rdata, mir[4]);
        mir[4] = 8'h3C;
        chk_all;
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            closed_loop_en <= c[2];
            photodiode_range_sel <= c[1:0];
            @(posedge clk);
            chk_scale;
        end
        // Reset in mid-run clears at once, without a clock edge
        @(posedge clk);
        reset <= 1'h1;
        @(negedge clk);
        chk(modulation_level_code, 8'h00);
        chk(bias_code, 10'h000);
        chk(reg_rd_valid, 1'h0);
        chk(positive_output_leg, 1'h1);
        chk(negative_output_leg, 1'h1);
        chk(bias_lsb_na, `TXC_OL_LSB_NA);
        foreach (mir[i]) mir[i] = 8'h00;
        @(posedge clk);
        reset <= 1'h0;
        chk_all;
        end_sim;
    end
endmodule : txc_tx_config_tb

// *** verilog/txc_cfg_reg.sv ***
`timescale 1ns/1ps
`include "txc_defs.svh"

module txc_cfg_reg #(
    parameter txc_pkg::txc_byte_t WRITE_MASK = `TXC_FULL_MASK
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire txc_pkg::txc_byte_t wdata,
    output txc_pkg::txc_byte_t value_q
);

    // Unimplemented bits never store, so they always read zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            value_q <= `TXC_RESET_VAL;
        end else if (wr_en) begin
            value_q <= wdata & WRITE_MASK;
        end
    end

endmodule : txc_cfg_reg

// *** verilog/txc_tx_config.sv ***
`timescale 1ns/1ps
`include "txc_defs.svh"

// Behaviour
// - Gain bit 7: one half amplitude range, zero full range.
// - Gain bit 6: one wide peaking, zero narrow peaking.
// - Gain bits 5:4 are the temperature compensation code, 5 high.
// - Gain bits 3:0 are input equalizer strength, 0000 weakest.
// - Modulation byte sets output swing, about 9.5 mVpp per step.
// - Output-mode bit 7 picks the live leg in single-ended mode.
// - Output-mode bit 6: one single-ended, zero differential.
// - Output-mode bit 5 delayed de-emphasis; bits 3:0 its strength.
// - Cross-point bit 7 direction; bits 6:0 shift size.
// - Bias code is ten bits; bias-high holds the upper eight.
// - Closed loop: photodiode range scales bias 0.75, 1.5 or 3 uA.
// - Open loop: about 156 uA of bias per code step.
// - All fields read and write, and reset to zero.
// - Bias low bits sit in bits 1:0 of the next register.
module txc_tx_config (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire txc_pkg::txc_addr_t reg_addr,
    input wire txc_pkg::txc_byte_t reg_wdata,
    input wire logic closed_loop_en,
    input wire logic [1:0] photodiode_range_sel,
    output txc_pkg::txc_byte_t reg_rdata,
    output logic reg_rd_valid,
    output logic amp_half_range_sel,
    output logic peaking_width_sel,
    output logic temp_comp_sel_hi,
    output logic temp_comp_sel_lo,
    output logic [3:0] input_eq_strength,
    output logic [7:0] modulation_level_code,
    output logic single_leg_select,
    output logic single_ended_sel,
    output logic delayed_deemph_sel,
    output logic slow_edge_sel,
    output logic [3:0] deemph_strength,
    output logic crosspoint_direction,
    output logic [6:0] crosspoint_magnitude,
    output logic [`TXC_BIAS_W-1:0] bias_code,
    output logic positive_output_leg,
    output logic negative_output_leg,
    output logic [`TXC_SWING_W-1:0] mod_swing_uvpp,
    output logic [`TXC_LSB_NA_W-1:0] bias_lsb_na
);

    localparam int NUM_REGS = `TXC_NUM_REGS;

    txc_pkg::txc_byte_t reg_q [NUM_REGS];
    logic [NUM_REGS-1:0] wr_hit;
    txc_pkg::txc_byte_t rdata_q;
    txc_pkg::txc_byte_t rdata_d;
    logic rd_valid_q;
    logic pos_leg_q;
    logic neg_leg_q;
    txc_pkg::txc_byte_t outm_d;
    logic [`TXC_SWING_W-1:0] swing_q;
    logic [`TXC_SWING_W-1:0] swing_d;
    logic [`TXC_LSB_NA_W-1:0] lsb_na_q;
    logic [`TXC_LSB_NA_W-1:0] lsb_na_d;

    // Address decode shared by the write strobes and the read mux
    function automatic logic txc_hit(
        input txc_pkg::txc_addr_t addr,
        input txc_pkg::txc_reg_t which
    );
        txc_hit = (addr == txc_pkg::txc_addr_t'(which));
    endfunction : txc_hit

    function automatic txc_pkg::txc_reg_t txc_slot(input int idx);
        txc_slot = txc_pkg::txc_reg_t'(`TXC_IDX_GAIN + idx[`TXC_ADDR_W-1:0]);
    endfunction : txc_slot

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            localparam txc_pkg::txc_byte_t MASK =
                (gi == NUM_REGS - 1) ? `TXC_BIASL_MASK : `TXC_FULL_MASK;

            assign wr_hit[gi] = reg_wr_en && txc_hit(reg_addr, txc_slot(gi));

            // Every field stores on write and resets to zero
            txc_cfg_reg #(
                .WRITE_MASK(MASK)
            ) u_reg (
                .clk(clk),
                .reset(reset),
                .wr_en(wr_hit[gi]),
                .wdata(reg_wdata),
                .value_q(reg_q[gi])
            );
        end
    endgenerate

    // Raw fields come straight from the register flops
    assign amp_half_range_sel = reg_q[0][`TXC_AMP_RNG_BIT];
    assign peaking_width_sel = reg_q[0][`TXC_PK_BIT];
    assign temp_comp_sel_hi = reg_q[0][`TXC_TC_HI_BIT];
    assign temp_comp_sel_lo = reg_q[0][`TXC_TC_LO_BIT];
    assign input_eq_strength = reg_q[0][`TXC_EQ_MSB:`TXC_EQ_LSB];
    assign modulation_level_code = reg_q[1];
    assign single_leg_select = reg_q[2][`TXC_LEG_BIT];
    assign single_ended_sel = reg_q[2][`TXC_SE_BIT];
    assign delayed_deemph_sel = reg_q[2][`TXC_DLY_BIT];
    assign slow_edge_sel = reg_q[2][`TXC_SLOW_BIT];
    assign deemph_strength = reg_q[2][`TXC_DE_MSB:`TXC_DE_LSB];
    assign crosspoint_direction = reg_q[3][`TXC_XDIR_BIT];
    assign crosspoint_magnitude = reg_q[3][`TXC_XMAG_MSB:`TXC_XMAG_LSB];
    assign bias_code = {reg_q[4],
        reg_q[5][`TXC_BIASL_MSB:`TXC_BIASL_LSB]};

    // Leg enables track the mode register's next value, so they move
    // on the same edge as the raw fields instead of one cycle later
    always_comb begin
        outm_d = wr_hit[2] ? reg_wdata : reg_q[2];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_leg_q <= 1'b1;
            neg_leg_q <= 1'b1;
        end else begin
            pos_leg_q <= !outm_d[`TXC_SE_BIT] ||
                !outm_d[`TXC_LEG_BIT];
            neg_leg_q <= !outm_d[`TXC_SE_BIT] ||
                outm_d[`TXC_LEG_BIT];
        end
    end

    // Nominal swing estimate for monitoring; analog trim is not modelled
    always_comb begin
        swing_d = `TXC_MOD_STEP_UVPP * (wr_hit[1] ? {14'h0000, reg_wdata}
            : {14'h0000, reg_q[1]});
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            swing_q <= '0;
        end else begin
            swing_q <= swing_d;
        end
    end

    // Bias current per code; the coupling ratio is applied outside
    always_comb begin
        if (!closed_loop_en) begin
            lsb_na_d = `TXC_OL_LSB_NA;
        end else if (photodiode_range_sel == `TXC_PD_RNG_FINE) begin
            lsb_na_d = `TXC_PD_LSB_NA_FINE;
        end else if (photodiode_range_sel == `TXC_PD_RNG_MID) begin
            lsb_na_d = `TXC_PD_LSB_NA_MID;
        end else begin
            lsb_na_d = `TXC_PD_LSB_NA_COARSE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lsb_na_q <= `TXC_OL_LSB_NA;
        end else begin
            lsb_na_q <= lsb_na_d;
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        rdata_d = `TXC_READ_NONE;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (txc_hit(reg_addr, txc_slot(i))) begin
                rdata_d = reg_q[i];
            end
        end
    end

    // A read in the cycle of a write returns the value before the write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= `TXC_READ_NONE;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_rd_en;
            if (reg_rd_en) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;
    assign positive_output_leg = pos_leg_q;
    assign negative_output_leg = neg_leg_q;
    assign mod_swing_uvpp = swing_q;
    assign bias_lsb_na = lsb_na_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic wr_gain;
    logic wr_outm;
    assign wr_gain = reg_wr_en && reg_addr == `TXC_IDX_GAIN;
    assign wr_outm = reg_wr_en && reg_addr == `TXC_IDX_OUTM;

    a_amp_range_bit: assert property (
        wr_gain |=> amp_half_range_sel == $past(reg_wdata[7]))
        else $error("amplitude range bit not stored");

    a_peaking_width_bit: assert property (
        wr_gain |=> peaking_width_sel == $past(reg_wdata[6]))
        else $error("peaking width bit not stored");

    a_temp_comp_code: assert property (
        wr_gain |=> {temp_comp_sel_hi, temp_comp_sel_lo}
            == $past(reg_wdata[5:4]))
        else $error("temperature compensation code wrong");

    a_eq_strength_code: assert property (
        wr_gain ##1 !reg_wr_en |=>
            input_eq_strength == $past(reg_wdata[`TXC_EQ_MSB:`TXC_EQ_LSB], 2))
        else $error("equalizer strength not held");

    a_mod_swing_track: assert property (
        reg_wr_en && reg_addr == `TXC_IDX_MOD |=>
            modulation_level_code == $past(reg_wdata) &&
            mod_swing_uvpp == 22'(modulation_level_code) * `TXC_MOD_STEP_UVPP)
        else $error("modulation code or swing wrong");

    a_single_leg_pick: assert property (
        wr_outm && reg_wdata[6] |=>
            negative_output_leg == single_leg_select &&
            positive_output_leg == !single_leg_select)
        else $error("single-ended leg selection wrong");

    a_diff_both_legs: assert property (
        wr_outm && !reg_wdata[6] |=> !single_ended_sel &&
            positive_output_leg && negative_output_leg)
        else $error("differential mode must drive both legs");

    a_deemph_fields: assert property (
        wr_outm |=> delayed_deemph_sel == $past(reg_wdata[5]) &&
            deemph_strength == $past(reg_wdata[3:0]))
        else $error("de-emphasis fields wrong");

    a_slow_edge_bit: assert property (
        wr_outm |=> slow_edge_sel == $past(reg_wdata[4]))
        else $error("slow edge bit wrong");

    a_crosspoint_fields: assert property (
        reg_wr_en && reg_addr == `TXC_IDX_XPT |=>
            {crosspoint_direction, crosspoint_magnitude}
                == $past(reg_wdata))
        else $error("cross-point fields wrong");

    a_bias_high_bits: assert property (
        reg_wr_en && reg_addr == `TXC_IDX_BIASH |=>
            bias_code[9:2] == $past(reg_wdata))
        else $error("bias upper bits wrong");

    a_pd_range_scale: assert property (
        // The edge that releases reset still loads the open-loop step
        closed_loop_en && photodiode_range_sel[1] && !reset |=>
            bias_lsb_na == `TXC_PD_LSB_NA_COARSE)
        else $error("coarse photodiode range scale wrong");

    a_open_loop_step: assert property (
        !closed_loop_en |=> bias_lsb_na == `TXC_OL_LSB_NA)
        else $error("open loop bias step wrong");

    a_reset_zero: assert property (
        @(posedge clk) disable iff (1'b0)
        reset |=> reset || (modulation_level_code == 8'h00 &&
            bias_code == 10'h000 && input_eq_strength == 4'h0))
        else $error("fields not zero after reset");

    a_bias_low_bits: assert property (
        reg_wr_en && reg_addr == `TXC_IDX_BIASL ##1 !reg_wr_en |=>
            bias_code[1:0] == $past(reg_wdata[1:0], 2))
        else $error("bias low bits wrong");

    a_readback_value: assert property (
        reg_rd_en && !reg_wr_en && reg_addr == `TXC_IDX_MOD |=>
            reg_rd_valid && reg_rdata == modulation_level_code)
        else $error("read-back differs from stored value");

    a_unmapped_reads: assert property (
        reg_rd_en && (reg_addr < `TXC_IDX_GAIN || reg_addr > `TXC_IDX_BIASL)
            |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    c_single_ended_neg: cover property (
        wr_outm && reg_wdata[7:6] == 2'h3 ##1 negative_output_leg);
    c_bias_full_code: cover property (bias_code == 10'h3FF);
    c_read_after_write: cover property (
        reg_wr_en ##1 reg_rd_en && reg_addr == $past(reg_addr));

endmodule : txc_tx_config
